// ==== global_control_registers.sv ====
// Global control and status register bank of an eight-link line device,
// reached over AXI4-Lite. Pins and clocks from outside are synchronised;
// link interrupt lines and counter bytes come from logic on aclk.
//
// Function
// - Monitor codes 0000 and 1000 connect nothing to monitoring link one.
// - Top bit clear, low part nonzero: receiver of link low+1 is monitored.
// - Top bit set, low part nonzero: transmitter of link low+1 is monitored.
// - Direction bit 0 makes a GPIO pin output, 1 makes it input.
// - Output pin level bit is read/write; pin drives that level.
// - Input pin level bit is read-only and returns the pin level.
// - Second reference select routes link code+1 recovered clock to its pin.
// - First reference select routes link code+1 recovered clock to its pin.
// - Summary bit reads 1 while its link has an interrupt pending.
// - Interrupt asserts for the tick only when enabled and flag set.
// - Timer sets the tick flag at each one-second interval.
// - Writing 1 clears the tick flag; writing 0 leaves it.
// - Counter link select picks link code+1 for indirect reads.
// - Four-bit indirect address picks a counter byte of that link.
// - Read-only data register returns the selected counter byte.
// - Monitor select sits in the low four bits; upper bits reserved.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "gcr_consts.svh"

module global_control_registers #(
  parameter int unsigned TICK_CYCLES = `GCR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Monitor path control
  output logic             monitor_enable,
  output logic             monitor_transmit,
  output logic [2:0]       monitor_link,
  // General purpose pins
  input  wire logic [1:0]  gpio_in,
  output logic [1:0]       gpio_out,
  output logic [1:0]       gpio_oe,
  // Recovered clocks and reference outputs
  input  wire logic [7:0]  recovered_clk,
  output logic             first_ref_clock_out,
  output logic             second_ref_clock_out,
  // Link interrupts and counters
  input  wire logic [7:0]  link_irq_pending,
  output logic [2:0]       counter_link_select,
  output logic [3:0]       counter_address,
  input  wire logic [7:0]  counter_read_byte,
  // Interrupt
  output logic             irq
);

  // --------------------------------------------------------------------------
  // Address decoding
  // --------------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[7:2] == idx);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = reg_hit(a, `GCR_IDX_MONITOR) | reg_hit(a, `GCR_IDX_GPIO) |
             reg_hit(a, `GCR_IDX_REFCLK) | reg_hit(a, `GCR_IDX_LINK_SUM) |
             reg_hit(a, `GCR_IDX_TICK_EN) | reg_hit(a, `GCR_IDX_TICK_FLAG) |
             reg_hit(a, `GCR_IDX_CNT_SEL) | reg_hit(a, `GCR_IDX_CNT_DATA) |
             reg_hit(a, `GCR_IDX_IRQ_STATUS) | reg_hit(a, `GCR_IDX_IRQ_ENABLE) |
             reg_hit(a, `GCR_IDX_IRQ_CLEAR);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic       aw_held_reg;
  logic       w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic       wlane_reg;
  logic [3:0] monitor_path_select_reg;
  logic [1:0] gpio_dir_reg;
  logic [1:0] gpio_level_reg;
  logic [2:0] first_ref_source_reg;
  logic [2:0] second_ref_source_reg;
  logic [7:0] link_summary_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic [7:0] counter_byte_reg;
  logic       link_any_reg;
  logic [1:0] gpio_meta_reg;
  logic [1:0] gpio_sync_reg;
  logic [7:0] rclk_meta_reg;
  logic [7:0] rclk_sync_reg;
  logic       second_tick;

  second_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_second_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (second_tick)
  );

  // --------------------------------------------------------------------------
  // Read selection
  // --------------------------------------------------------------------------
  // Pin level read: synchronised pin for input pins, level register for output pins
  wire [1:0] gpio_level_rd = (gpio_dir_reg & gpio_sync_reg) | (~gpio_dir_reg & gpio_level_reg);
  wire [7:0] gpio_rd = {4'h0, gpio_level_rd, gpio_dir_reg};
  wire [7:0] ref_rd  = {2'b00, second_ref_source_reg, first_ref_source_reg};
  wire [7:0] csel_rd = {counter_link_select, 1'b0, counter_address};
  wire [7:0] rd_value =
    reg_hit(s_axi_araddr, `GCR_IDX_MONITOR)    ? {4'h0, monitor_path_select_reg} :
    reg_hit(s_axi_araddr, `GCR_IDX_GPIO)       ? gpio_rd :
    reg_hit(s_axi_araddr, `GCR_IDX_REFCLK)     ? ref_rd :
    reg_hit(s_axi_araddr, `GCR_IDX_LINK_SUM)   ? link_summary_reg :
    reg_hit(s_axi_araddr, `GCR_IDX_TICK_EN)    ? {7'h00, irq_enable_reg[0]} :
    reg_hit(s_axi_araddr, `GCR_IDX_TICK_FLAG)  ? {7'h00, irq_status_reg[0]} :
    reg_hit(s_axi_araddr, `GCR_IDX_CNT_SEL)    ? csel_rd :
    reg_hit(s_axi_araddr, `GCR_IDX_CNT_DATA)   ? counter_byte_reg :
    reg_hit(s_axi_araddr, `GCR_IDX_IRQ_STATUS) ? {6'h00, irq_status_reg} :
    reg_hit(s_axi_araddr, `GCR_IDX_IRQ_ENABLE) ? {6'h00, irq_enable_reg} :
    8'h00;

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // The write is committed one cycle after both halves are held, so the
  // address and data always come from registers and never from the bus.
  wire aw_fire    = s_axi_awvalid & s_axi_awready;
  wire w_fire     = s_axi_wvalid & s_axi_wready;
  wire ar_fire    = s_axi_arvalid & s_axi_arready;
  wire do_write   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire aw_next    = (aw_held_reg | aw_fire) & ~do_write;
  wire w_next     = (w_held_reg | w_fire) & ~do_write;
  wire bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_nxt = ar_fire | (s_axi_rvalid & ~s_axi_rready);

  // Byte lane 0 carries every register; a write without it changes nothing.
  wire       wr_ok   = do_write & wlane_reg & mapped(awaddr_reg);
  wire       wr_mon  = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_MONITOR);
  wire       wr_gpio = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_GPIO);
  wire       wr_ref  = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_REFCLK);
  wire       wr_ten  = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_TICK_EN);
  wire       wr_tflg = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_TICK_FLAG);
  wire       wr_csel = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_CNT_SEL);
  wire       wr_ien  = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_IRQ_ENABLE);
  wire       wr_iclr = wr_ok & reg_hit(awaddr_reg, `GCR_IDX_IRQ_CLEAR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 8'h00;
      wlane_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gcr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= gcr_pkg::RESP_OKAY;
    end else begin
      aw_held_reg   <= aw_next;
      w_held_reg    <= w_next;
      s_axi_awready <= ~aw_next & ~bvalid_nxt;
      s_axi_wready  <= ~w_next & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (aw_fire) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_reg <= s_axi_wdata[7:0];
        wlane_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= mapped(awaddr_reg) ? gcr_pkg::RESP_OKAY : gcr_pkg::RESP_SLVERR;
      end
      if (ar_fire) begin
        s_axi_rdata <= {24'h000000, rd_value};
        s_axi_rresp <= mapped(s_axi_araddr) ? gcr_pkg::RESP_OKAY : gcr_pkg::RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_path_select_reg <= 4'h0;
      gpio_dir_reg            <= 2'(`GCR_GPIO_RESET >> `GCR_GPIO_DIR_LSB);
      gpio_level_reg          <= 2'b00;
      first_ref_source_reg    <= 3'h0;
      second_ref_source_reg   <= 3'h0;
      counter_link_select     <= 3'h0;
      counter_address         <= 4'h0;
    end else begin
      if (wr_mon) begin
        monitor_path_select_reg <= wdata_reg[3:0];
      end
      if (wr_gpio) begin
        gpio_dir_reg <= wdata_reg[`GCR_GPIO_DIR_LSB +: 2];
        for (int i = 0; i < 2; i++) begin
          if (!gpio_dir_reg[i]) begin
            gpio_level_reg[i] <= wdata_reg[`GCR_GPIO_LVL_LSB + i];
          end
        end
      end
      if (wr_ref) begin
        first_ref_source_reg  <= wdata_reg[`GCR_REF1_LSB +: 3];
        second_ref_source_reg <= wdata_reg[`GCR_REF2_LSB +: 3];
      end
      if (wr_csel) begin
        counter_link_select <= wdata_reg[`GCR_CNT_LINK_LSB +: 3];
        counter_address     <= wdata_reg[`GCR_CNT_ADDR_LSB +: 4];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin and clock synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_meta_reg <= 2'b00;
      gpio_sync_reg <= 2'b00;
      rclk_meta_reg <= 8'h00;
      rclk_sync_reg <= 8'h00;
    end else begin
      gpio_meta_reg <= gpio_in;
      gpio_sync_reg <= gpio_meta_reg;
      rclk_meta_reg <= recovered_clk;
      rclk_sync_reg <= rclk_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs: monitor path, pins, reference clocks
  // --------------------------------------------------------------------------
  // The recovered clocks are oversampled, so each reference output carries
  // up to one aclk period of jitter; fine for line rates far below aclk.
  wire mon_active = (monitor_path_select_reg[2:0] != 3'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      monitor_enable       <= 1'b0;
      monitor_transmit     <= 1'b0;
      monitor_link         <= 3'h0;
      gpio_out             <= 2'b00;
      gpio_oe              <= 2'b00;
      first_ref_clock_out  <= 1'b0;
      second_ref_clock_out <= 1'b0;
    end else begin
      monitor_enable   <= mon_active;
      monitor_transmit <= monitor_path_select_reg[3] == gcr_pkg::PATH_TRANSMITTER;
      monitor_link     <= monitor_path_select_reg[2:0];
      gpio_oe  <= ~(wr_gpio ? wdata_reg[`GCR_GPIO_DIR_LSB +: 2] : gpio_dir_reg);
      gpio_out <= gpio_level_reg;
      first_ref_clock_out  <= rclk_sync_reg[first_ref_source_reg];
      second_ref_clock_out <= rclk_sync_reg[second_ref_source_reg];
    end
  end

  // --------------------------------------------------------------------------
  // Link summary, counter data, interrupts
  // --------------------------------------------------------------------------
  wire       link_any   = |link_irq_pending;
  wire [1:0] irq_events = {link_any & ~link_any_reg, second_tick};
  wire [1:0] clr_tflg   = {1'b0, wr_tflg & wdata_reg[0]};
  wire [1:0] clr_iclr   = wr_iclr ? wdata_reg[1:0] : 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_summary_reg <= `GCR_ZERO_RESET;
      counter_byte_reg <= `GCR_ZERO_RESET;
      link_any_reg     <= 1'b0;
      irq_status_reg   <= 2'b00;
      irq_enable_reg   <= 2'b00;
      irq              <= 1'b0;
    end else begin
      link_summary_reg <= link_irq_pending;
      counter_byte_reg <= counter_read_byte;
      link_any_reg     <= link_any;
      irq_status_reg <= (irq_status_reg & ~(clr_tflg | clr_iclr)) | irq_events;
      if (wr_ien) begin
        irq_enable_reg <= wdata_reg[1:0];
      end else if (wr_ten) begin
        irq_enable_reg[0] <= wdata_reg[0];
      end
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_mon_off;
    ($past(monitor_path_select_reg[2:0]) == 3'h0) |-> !monitor_enable;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("monitor active on null code");

  property p_mon_rx;
    (monitor_enable && !monitor_transmit) |->
      ($past(monitor_path_select_reg) == {1'b0, monitor_link}) && (monitor_link != 3'h0);
  endproperty
  a_mon_rx: assert property (p_mon_rx) else $error("receiver monitor mismatch");

  property p_mon_tx;
    (monitor_enable && monitor_transmit) |->
      $past(monitor_path_select_reg) == {1'b1, monitor_link};
  endproperty
  a_mon_tx: assert property (p_mon_tx) else $error("transmitter monitor mismatch");

  property p_gpio_drive;
    !$past(wr_gpio) |->
      (gpio_oe == ~$past(gpio_dir_reg)) && (gpio_out == $past(gpio_level_reg));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("pin drive mismatch");

  property p_ref_route;
    first_ref_clock_out == $past(rclk_sync_reg[first_ref_source_reg]);
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("first reference not routed");

  property p_summary;
    ##1 link_summary_reg == $past(link_irq_pending);
  endproperty
  a_summary: assert property (p_summary) else $error("link summary stale");

  property p_irq_gate;
    irq |-> $past(irq_status_reg[0] && irq_enable_reg[0]) ||
            $past(irq_status_reg[1] && irq_enable_reg[1]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enabled flag");

  property p_tick_sets;
    second_tick |=> irq_status_reg[0] ##1 (irq == $past(irq_enable_reg[0]) || irq);
  endproperty
  a_tick_sets: assert property (p_tick_sets) else $error("tick did not set flag");

  property p_flag_clear;
    (wr_tflg && wdata_reg[0] && !second_tick) |=> !irq_status_reg[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by one");

  property p_write_resp;
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

  c_tick_irq: cover property (second_tick && irq_enable_reg[0] ##2 irq);
  c_gpio_in:  cover property (ar_fire && reg_hit(s_axi_araddr, `GCR_IDX_GPIO) && gpio_dir_reg[0]);
  c_mon_tx:   cover property (monitor_enable && monitor_transmit);
  c_flag_clr: cover property (wr_tflg && wdata_reg[0] && irq_status_reg[0]);

endmodule

// ==== gcr_consts.svh ====
// Register offsets, field positions, reset values and timing counts of the
// global control register bank. Included by the bank and its timer module.
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define GCR_IDX_MONITOR     6'h05
`define GCR_IDX_GPIO        6'h06
`define GCR_IDX_REFCLK      6'h07
`define GCR_IDX_LINK_SUM    6'h09
`define GCR_IDX_TICK_EN     6'h0A
`define GCR_IDX_TICK_FLAG   6'h0B
`define GCR_IDX_CNT_SEL     6'h0E
`define GCR_IDX_CNT_DATA    6'h0F
`define GCR_IDX_IRQ_STATUS  6'h10
`define GCR_IDX_IRQ_ENABLE  6'h11
`define GCR_IDX_IRQ_CLEAR   6'h12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define GCR_GPIO_DIR_LSB    0
`define GCR_GPIO_LVL_LSB    2
`define GCR_REF1_LSB        0
`define GCR_REF2_LSB        3
`define GCR_CNT_ADDR_LSB    0
`define GCR_CNT_LINK_LSB    5
`define GCR_IRQ_TICK_BIT    0
`define GCR_IRQ_LINK_BIT    1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GCR_GPIO_RESET      8'h03
`define GCR_ZERO_RESET      8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define GCR_CLK_PERIOD_NS   8
`define GCR_TICK_PERIOD_NS  1000000000
`define GCR_TICK_CYCLES     (`GCR_TICK_PERIOD_NS / `GCR_CLK_PERIOD_NS)

`endif

// ==== gcr_pkg.sv ====
// Types shared by the global control register bank.
// Assumes the constants header is included by each user.
package gcr_pkg;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_type;

  typedef enum logic [0:0] {
    PATH_RECEIVER    = 1'b0,
    PATH_TRANSMITTER = 1'b1
  } monitor_path_type;

endpackage

// ==== second_timer.sv ====
// Free running interval timer giving a one-cycle pulse per interval.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "gcr_consts.svh"

module second_timer #(
  parameter int unsigned TICK_CYCLES = `GCR_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Interval pulse
  output logic      tick
);

  localparam logic [31:0] LAST = 32'(TICK_CYCLES - 1);

  logic [31:0] count_reg;
  wire         at_end = (count_reg == LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h00000000;
      tick      <= 1'b0;
    end else begin
      count_reg <= at_end ? 32'h00000000 : count_reg + 32'h00000001;
      tick      <= at_end;
    end
  end

endmodule

// ==== gcr_host.sv ====
// AXI4-Lite master standing in for the host processor of the register bank.
// Assumes one clock and that the bench calls one task at a time.
`timescale 1ns/1ns

module gcr_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // Read channels
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
  end

  // Released payloads are inverted so a late sample by the slave shows up.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// ==== global_control_registers_test.sv ====
// Self-checking bench of the global control register bank.
// Assumes the host model drives the register bus; pins are driven here.
`timescale 1ns/1ns
`include "gcr_consts.svh"

module global_control_registers_test;
  localparam int unsigned TICKS = 40;
  logic        aclk, aresetn, irq, monitor_enable, monitor_transmit;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, first_ref_clock_out, second_ref_clock_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, recovered_clk, link_irq_pending;
  logic [7:0]  counter_read_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [3:0]  s_axi_wstrb, counter_address;
  logic [2:0]  monitor_link, counter_link_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, gpio_in, gpio_out, gpio_oe;
  int          mismatches, n_tests, a;

  gcr_host u_gcr_host (.*);
  global_control_registers #(.TICK_CYCLES(TICKS)) u_global_control_registers (.*);

  always #4 aclk = ~aclk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int idx, input int d, input logic [1:0] er = gcr_pkg::RESP_OKAY);
    logic [1:0] r;
    u_gcr_host.wr(8'(idx * 4), 32'(d), r);
    check(32'(r), 32'(er));
  endtask

  // A zero mask checks only the response code.
  task automatic rdc(input int idx, input int e, input int m = -1,
                     input logic [1:0] er = gcr_pkg::RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    u_gcr_host.rd(8'(idx * 4), d, r);
    check(32'(r), 32'(er));
    if (m != 0) check(d & 32'(m), 32'(e));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 100) begin
      @(posedge aclk);
      n++;
    end
    check(irq, lvl);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole sequence needs several hundred cycles; this is a generous cap.
  initial begin
    cyc(20000);
    mismatches++;
    results();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    gpio_in = 2'b00;
    recovered_clk = 8'h00;
    link_irq_pending = 8'h00;
    counter_read_byte = 8'h00;
    rnd = 32'h0EB0;
    cyc(16);
    aresetn <= 1'b1;
    rdc(`GCR_IDX_TICK_FLAG, 0);
    rdc(`GCR_IDX_GPIO, `GCR_GPIO_RESET);
    check(gpio_oe, 2'b00);
    rdc(`GCR_IDX_REFCLK, 0);
    rdc(`GCR_IDX_TICK_EN, 0);
    rdc(`GCR_IDX_CNT_SEL, 0);
    wr(1, 0, gcr_pkg::RESP_SLVERR);
    rdc(8'h20, 0, 0, gcr_pkg::RESP_SLVERR);
    for (int m = 0; m < 16; m++) begin
      wr(`GCR_IDX_MONITOR, m | 'hF0);
      cyc(1);
      check(monitor_enable, (m & 7) != 0);
      if ((m & 7) != 0) begin
        check(monitor_transmit, m >> 3);
        check(monitor_link, m & 7);
      end
      rdc(`GCR_IDX_MONITOR, m);
    end
    for (int i = 0; i < 16; i++) begin
      wr(`GCR_IDX_REFCLK, (i & 7) | ((7 - (i & 7)) << 3));
      rnd = nxt(rnd);
      recovered_clk <= rnd[7:0];
      cyc(6);
      check(first_ref_clock_out, rnd[i & 7]);
      check(second_ref_clock_out, rnd[7 - (i & 7)]);
      rdc(`GCR_IDX_REFCLK, (i & 7) | ((7 - (i & 7)) << 3));
    end
    wr(`GCR_IDX_GPIO, 0);
    wr(`GCR_IDX_GPIO, 'h08);
    cyc(1);
    check(gpio_oe, 2'b11);
    check(gpio_out, 2'b10);
    rdc(`GCR_IDX_GPIO, 'h08);
    gpio_in <= 2'b10;
    wr(`GCR_IDX_GPIO, 'h06);
    cyc(3);
    check(gpio_oe, 2'b01);
    check(gpio_out[0], 1'b1);
    rdc(`GCR_IDX_GPIO, 'h0E);
    wr(`GCR_IDX_GPIO, 'h0A);
    gpio_in <= 2'b00;
    cyc(3);
    check(gpio_out[0], 1'b0);
    check(gpio_out[1], 1'b0);
    rdc(`GCR_IDX_GPIO, 'h02);
    repeat (3) begin
      rnd = nxt(rnd);
      link_irq_pending <= rnd[7:0];
      cyc(3);
      rdc(`GCR_IDX_LINK_SUM, rnd[7:0]);
    end
    link_irq_pending <= 8'h00;
    wr(`GCR_IDX_IRQ_CLEAR, 3);
    link_irq_pending <= 8'h10;
    cyc(4);
    check(irq, 1'b0);
    rdc(`GCR_IDX_IRQ_STATUS, 2, 2);
    wr(`GCR_IDX_IRQ_ENABLE, 2);
    wait_irq(1'b1);
    wr(`GCR_IDX_IRQ_CLEAR, 2);
    wait_irq(1'b0);
    rdc(`GCR_IDX_IRQ_STATUS, 0, 2);
    for (int l = 0; l < 8; l++) begin
      rnd = nxt(rnd);
      a = int'(rnd[15:0] % 12);
      wr(`GCR_IDX_CNT_SEL, (l << 5) | a);
      counter_read_byte <= rnd[31:24];
      cyc(2);
      check(counter_link_select, l);
      check(counter_address, a);
      rdc(`GCR_IDX_CNT_DATA, rnd[31:24]);
      rdc(`GCR_IDX_CNT_SEL, (l << 5) | a);
    end
    wr(`GCR_IDX_TICK_EN, 1);
    wait_irq(1'b1);
    wr(`GCR_IDX_TICK_FLAG, 1);
    wr(`GCR_IDX_IRQ_CLEAR, 1);
    wait_irq(1'b0);
    wait_irq(1'b1);
    wr(`GCR_IDX_TICK_FLAG, 0);
    rdc(`GCR_IDX_TICK_FLAG, 1);
    wr(`GCR_IDX_TICK_FLAG, 1);
    rdc(`GCR_IDX_TICK_FLAG, 0);
    wr(`GCR_IDX_TICK_EN, 0);
    cyc(TICKS + 5);
    check(irq, 1'b0);
    rdc(`GCR_IDX_TICK_FLAG, 1);
    results();
  end
endmodule
